// ===== hw/ext_irq_detect.sv
// Dedicated external interrupt pins: synchroniser, edge and low-level detect.
// Assumes ioClkEn is high while the I/O clock runs (always outside sleep).
`timescale 1ns/1ns
`include "irq_ctl_params.svh"

module ext_irq_detect
  import irq_ctl_pkg::*;
(
  // Clock and reset
  input  wire logic                     clk,
  input  wire logic                     rst,
  // Pins and control
  input  wire logic [`EXT_PINS-1:0]     pinLevel,
  input  wire logic                     ioClkEn,
  input  wire logic [2*`EXT_PINS-1:0]   senseCodes,
  // Detected events
  output logic      [`EXT_PINS-1:0]     edgeEvent,
  output logic      [`EXT_PINS-1:0]     levelLow
);

  ext_det_s q;
  ext_det_s d;

  always_comb begin
    sense_e s;
    s = SENSE_LOW;
    d = q;
    d.sync1 = pinLevel;
    d.sync2 = q.sync1;
    // Prev always tracks: no edge replayed after sleep
    d.prev  = q.sync2;
    for (int i = 0; i < `EXT_PINS; i++) begin
      s = sense_e'(senseCodes[2*i +: 2]);
      d.edgeEvent[i] = 1'b0;
      if (ioClkEn) begin
        case (s)
          SENSE_CHANGE: d.edgeEvent[i] = q.sync2[i] ^ q.prev[i];
          SENSE_FALL:   d.edgeEvent[i] = q.prev[i] & ~q.sync2[i];
          SENSE_RISE:   d.edgeEvent[i] = ~q.prev[i] & q.sync2[i];
          default:      d.edgeEvent[i] = 1'b0;
        endcase
      end
      // Low level needs no I/O clock
      d.levelLow[i] = (s == SENSE_LOW) & ~q.sync2[i];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign edgeEvent = q.edgeEvent;
  assign levelLow  = q.levelLow;

endmodule

// ===== hw/irq_ctl_params.svh
// Constants of the interrupt-side control block: addresses, bit positions,
// counts and vector layout. Included by the package and every design file.
`ifndef IRQ_CTL_PARAMS_SVH
`define IRQ_CTL_PARAMS_SVH

// ----------------------------------------------------------------------
// Control register placement
// ----------------------------------------------------------------------
`define MCU_CONTROL_DATA_ADDR 8'h55
`define IO_SPACE_OFFSET       8'h20
`define MCU_CONTROL_RESET     8'h00

// ----------------------------------------------------------------------
// Control register bit positions
// ----------------------------------------------------------------------
`define BIT_VEC_UNLOCK  0
`define BIT_VEC_SELECT  1
`define BIT_PULLUP_KILL 4
`define BIT_BOD_UNLOCK  5
`define BIT_BOD_OFF     6

// ----------------------------------------------------------------------
// Timed sequences, in clock cycles
// ----------------------------------------------------------------------
`define UNLOCK_WINDOW 3'h4
`define BROWNOUT_OFF_IN_SLEEP_LIFE     3'h3
`define BROWNOUT_OFF_IN_SLEEP_EFF_END  3'h6

// ----------------------------------------------------------------------
// Widths and vector layout
// ----------------------------------------------------------------------
`define EXT_PINS      2
`define PC_PINS       24
`define PC_GROUPS     3
`define FLASH_AW      14
`define APP_TABLE     14'h0000
`define BOOT_START_00 14'h3800
`define BOOT_START_01 14'h3c00
`define BOOT_START_10 14'h3e00
`define BOOT_START_11 14'h3f00
`define VEC_IDX_EXT0  3'h1
`define VEC_IDX_PC0   3'h3
`define PC_GROUP0     24'h0000ff
`define PC_GROUP1     24'h007f00
`define PC_GROUP2     24'hff0000

`endif

// ===== hw/irq_ctl_pkg.sv
// Types shared by the interrupt-side control block and its detectors.
// Assumes irq_ctl_params.svh supplies the widths.
`include "irq_ctl_params.svh"

package irq_ctl_pkg;

  // Sense code of a dedicated external pin
  typedef enum logic [1:0] {
    SENSE_LOW    = 2'h0,
    SENSE_CHANGE = 2'h1,
    SENSE_FALL   = 2'h2,
    SENSE_RISE   = 2'h3
  } sense_e;

  // Vector-change sequence, Gray along idle -> open -> hold
  typedef enum logic [1:0] {
    VC_IDLE = 2'h0,
    VC_OPEN = 2'h1,
    VC_HOLD = 2'h3
  } vec_change_e;

  typedef struct packed {
    logic                      req;
    logic [2:0]                index;
    logic [`FLASH_AW-1:0]      addr;
  } cpu_irq_s;

  typedef struct packed {
    logic [`EXT_PINS-1:0] sync1;
    logic [`EXT_PINS-1:0] sync2;
    logic [`EXT_PINS-1:0] prev;
    logic [`EXT_PINS-1:0] edgeEvent;
    logic [`EXT_PINS-1:0] levelLow;
  } ext_det_s;

  typedef struct packed {
    logic [`PC_PINS-1:0]   prev;
    logic [`PC_GROUPS-1:0] evt;
  } pc_det_s;

  typedef struct packed {
    vec_change_e           vcState;
    logic [2:0]            vecCnt;
    logic                  vecSel;
    logic                  pullupKill;
    logic [2:0]            bodUnlockCnt;
    logic                  bodsPending;
    logic [2:0]            bodsAge;
    logic                  bodsEffective;
    logic                  bodOffThisSleep;
    logic [`EXT_PINS-1:0]  extFlags;
    logic [`PC_GROUPS-1:0] pcFlags;
    cpu_irq_s              cpuIrq;
    logic [7:0]            rdata;
    logic [`FLASH_AW-1:0]  resetAddr;
    logic                  wakeReq;
    logic [`PC_PINS-2:0]   pullupEnable;
  } ctl_state_s;

endpackage

// ===== hw/irq_vector_select.sv
// Interrupt-side control: control register, vector placement, timed unlocks,
// external and pin-change requests, pull-up kill and brown-out-in-sleep.
// Assumes the CPU core drives a one-cycle register write/read strobe and
// pulses instrDone at every instruction boundary.
//
// Contract
// - Vector table at flash start when select is 0, boot start when 1.
// - Select change taken only within four cycles after unlock write.
// - Dispatch blocked from unlock until instruction after select write, else four cycles.
// - Automatic blocking leaves the CPU global interrupt enable untouched.
// - Unlock bit clears four cycles after write or on select write.
// - Boot lock bits disable interrupts while executing in the other section.
// - Brown-out-off bit set only by two-step timed write within four cycles.
// - Brown-out-off effective three cycles after set; sleep then disables detector.
// - Brown-out-off bit clears itself three cycles after being set.
// - Pull-up kill bit forces every port pull-up off.
// - Pin activity raises interrupts even for pins driven as outputs.
// - Pin-change requests 2,1,0 cover inputs 23:16, 14:8, 7:0 under masks.
// - Pin-change events detected without the I/O clock for wake.
// - External pins trigger on falling edge, rising edge or low level.
// - Level mode keeps requesting while the pin stays low.
// - Edge detection uses the I/O clock, so no edges in deep sleep.
// - Low level detected without the I/O clock for wake.
// - Level wake always wakes; interrupt only if low still holds afterwards.
// - With fuse, select 1 and 2K boot, reset at 0x3C00 and vectors from 0x3C02.
// - Control register at data offset 0x55 and I/O address 0x35.
// - Sense codes: 00 low, 01 change, 10 falling, 11 rising.
// - Edge flag set by event, cleared by vector or write-one, clear in level mode.
// - Reset address 0 or boot start; vector start is table base plus two.
`timescale 1ns/1ns
`include "irq_ctl_params.svh"

module irq_vector_select
  import irq_ctl_pkg::*;
(
  // Clock and reset
  input  wire logic                     clk,
  input  wire logic                     rst,
  // CPU register port
  input  wire logic                     regWrite,
  input  wire logic                     regRead,
  input  wire logic                     regIoSpace,
  input  wire logic [7:0]               regAddr,
  input  wire logic [7:0]               regWdata,
  output logic      [7:0]               regRdata,
  // CPU core status and handshake
  input  wire logic                     globalIrqEnable,
  input  wire logic                     instrDone,
  input  wire logic                     execInBoot,
  input  wire logic                     cpuIrqAck,
  input  wire logic                     sleepExec,
  input  wire logic                     ioClkEn,
  output cpu_irq_s                      cpuIrq,
  output logic      [`FLASH_AW-1:0]     resetAddr,
  output logic                          wakeReq,
  output logic                          bodOffThisSleep,
  // Fuses and lock bits, active high when programmed
  input  wire logic                     resetVectorFuse,
  input  wire logic [1:0]               bootSizeFuses,
  input  wire logic                     appLockBit,
  input  wire logic                     bootLockBit,
  // External interrupt pins and their control
  input  wire logic [`EXT_PINS-1:0]     extIrqPins,
  input  wire logic [2*`EXT_PINS-1:0]   extSenseControl,
  input  wire logic [`EXT_PINS-1:0]     extIrqEnable,
  input  wire logic [`EXT_PINS-1:0]     extFlagWriteOne,
  output logic      [`EXT_PINS-1:0]     extIrqFlags,
  // Pin-change inputs and their control
  input  wire logic [`PC_PINS-1:0]      pinChangeInput,
  input  wire logic [`PC_PINS-1:0]      pinChangeMask,
  input  wire logic [`PC_GROUPS-1:0]    pinChangeEnable,
  input  wire logic [`PC_GROUPS-1:0]    pcFlagWriteOne,
  output logic      [`PC_GROUPS-1:0]    pinChangeFlags,
  // Port pull-up control
  input  wire logic [`PC_PINS-2:0]      pinDirectionBit,
  input  wire logic [`PC_PINS-2:0]      pinOutputBit,
  output logic      [`PC_PINS-2:0]      pullupEnable
);

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic logic hitsControl(input logic [7:0] addr, input logic ioSpace);
    logic [7:0] dataAddr;
    dataAddr = ioSpace ? addr + `IO_SPACE_OFFSET : addr;
    return dataAddr == `MCU_CONTROL_DATA_ADDR;
  endfunction

  function automatic logic [`FLASH_AW-1:0] bootStart(input logic [1:0] size);
    logic [`FLASH_AW-1:0] a;
    a = `BOOT_START_11;
    if (size == 2'h0) begin
      a = `BOOT_START_00;
    end else if (size == 2'h1) begin
      a = `BOOT_START_01;
    end else if (size == 2'h2) begin
      a = `BOOT_START_10;
    end
    return a;
  endfunction

  function automatic logic [`FLASH_AW-1:0] vectorAddr(input logic [`FLASH_AW-1:0] base,
                                                      input logic [2:0] index);
    return base + {{(`FLASH_AW-4){1'b0}}, index, 1'b0};
  endfunction

  // ----------------------------------------------------------------------
  // Detectors
  // ----------------------------------------------------------------------
  logic [`EXT_PINS-1:0]  extEdge;
  logic [`EXT_PINS-1:0]  extLow;
  logic [`PC_GROUPS-1:0] pcEvent;

  // Pins are sampled whatever their direction
  ext_irq_detect u_ext (
    .clk        (clk),
    .rst        (rst),
    .pinLevel   (extIrqPins),
    .ioClkEn    (ioClkEn),
    .senseCodes (extSenseControl),
    .edgeEvent  (extEdge),
    .levelLow   (extLow)
  );

  pin_change_detect u_pc (
    .clk        (clk),
    .rst        (rst),
    .pins       (pinChangeInput),
    .mask       (pinChangeMask),
    .groupEvent (pcEvent)
  );

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  ctl_state_s q;
  ctl_state_s d;

  always_comb begin
    logic                   wr;
    logic                   blocked;
    logic                   lockBlock;
    logic [`FLASH_AW-1:0]   base;
    logic [`EXT_PINS-1:0]   extPend;
    logic [`EXT_PINS-1:0]   levelMode;
    logic [`PC_GROUPS-1:0]  pcPend;
    logic                   found;
    logic [2:0]             idx;
    logic [2:0]             ackIdx;
    d         = q;
    wr        = regWrite & hitsControl(regAddr, regIoSpace);
    found     = 1'b0;
    idx       = 3'h0;
    ackIdx    = q.cpuIrq.index;
    for (int i = 0; i < `EXT_PINS; i++) begin
      levelMode[i] = extSenseControl[2*i +: 2] == SENSE_LOW;
    end

    // ------------------------------------------------------------------
    // Vector-change sequence
    // ------------------------------------------------------------------
    case (q.vcState)
      VC_OPEN: begin
        if (wr && regWdata[`BIT_VEC_UNLOCK]) begin
          d.vecCnt = `UNLOCK_WINDOW;
        end else if (wr) begin
          d.vecSel  = regWdata[`BIT_VEC_SELECT];
          d.vecCnt  = 3'h0;
          d.vcState = VC_HOLD;
        end else if (q.vecCnt == 3'h1) begin
          d.vecCnt  = 3'h0;
          d.vcState = VC_IDLE;
        end else begin
          d.vecCnt = q.vecCnt - 3'h1;
        end
      end
      VC_HOLD: begin
        // Released once the instruction after the select write retires
        if (instrDone) begin
          d.vcState = VC_IDLE;
        end
      end
      default: begin
        if (wr && regWdata[`BIT_VEC_UNLOCK]) begin
          d.vecCnt  = `UNLOCK_WINDOW;
          d.vcState = VC_OPEN;
        end
      end
    endcase

    // ------------------------------------------------------------------
    // Pull-up kill and brown-out-off timed write
    // ------------------------------------------------------------------
    if (wr) begin
      d.pullupKill = regWdata[`BIT_PULLUP_KILL];
    end
    if (q.bodUnlockCnt != 3'h0) begin
      d.bodUnlockCnt = q.bodUnlockCnt - 3'h1;
    end
    if (wr && regWdata[`BIT_BOD_OFF] && regWdata[`BIT_BOD_UNLOCK]) begin
      d.bodUnlockCnt = `UNLOCK_WINDOW;
    end else if (wr && regWdata[`BIT_BOD_OFF] && q.bodUnlockCnt != 3'h0) begin
      d.bodUnlockCnt = 3'h0;
      d.bodsPending  = 1'b1;
      d.bodsAge      = 3'h0;
    end
    if (q.bodsPending || q.bodsEffective) begin
      d.bodsAge = q.bodsAge + 3'h1;
    end
    if (q.bodsPending && q.bodsAge == `BROWNOUT_OFF_IN_SLEEP_LIFE - 3'h1) begin
      d.bodsPending   = 1'b0;
      d.bodsEffective = 1'b1;
    end
    if (q.bodsEffective && q.bodsAge == `BROWNOUT_OFF_IN_SLEEP_EFF_END - 3'h1) begin
      d.bodsEffective = 1'b0;
    end
    if (sleepExec) begin
      d.bodOffThisSleep = q.bodsEffective;
    end else if (!d.bodsEffective && ioClkEn && !q.bodsEffective) begin
      d.bodOffThisSleep = q.bodOffThisSleep & ~instrDone;
    end

    // ------------------------------------------------------------------
    // Flags; a set in the same cycle as a clear wins
    // ------------------------------------------------------------------
    for (int i = 0; i < `EXT_PINS; i++) begin
      if (levelMode[i]) begin
        d.extFlags[i] = 1'b0;
      end else if (extEdge[i]) begin
        d.extFlags[i] = 1'b1;
      end else if (extFlagWriteOne[i] ||
                   (cpuIrqAck && ackIdx == `VEC_IDX_EXT0 + 3'(i))) begin
        d.extFlags[i] = 1'b0;
      end
    end
    for (int g = 0; g < `PC_GROUPS; g++) begin
      if (pcEvent[g]) begin
        d.pcFlags[g] = 1'b1;
      end else if (pcFlagWriteOne[g] ||
                   (cpuIrqAck && ackIdx == `VEC_IDX_PC0 + 3'(g))) begin
        d.pcFlags[g] = 1'b0;
      end
    end

    // ------------------------------------------------------------------
    // Dispatch
    // ------------------------------------------------------------------
    // Level request follows the pin, so a wake with no remaining low asks nothing
    extPend = extIrqEnable & (q.extFlags | (extLow & levelMode));
    pcPend  = pinChangeEnable & q.pcFlags;
    for (int i = `EXT_PINS + `PC_GROUPS - 1; i >= 0; i--) begin
      if (i < `EXT_PINS ? extPend[i] : pcPend[i - `EXT_PINS]) begin
        found = 1'b1;
        idx   = `VEC_IDX_EXT0 + 3'(i);
      end
    end
    lockBlock = (q.vecSel && appLockBit && !execInBoot) ||
                (!q.vecSel && bootLockBit && execInBoot);
    // Only the request is masked; the CPU's own enable bit is never written
    blocked = (d.vcState != VC_IDLE) || (q.vcState != VC_IDLE) || lockBlock;
    base    = q.vecSel ? bootStart(bootSizeFuses) : `APP_TABLE;
    d.cpuIrq.req   = found && globalIrqEnable && !blocked && !cpuIrqAck;
    d.cpuIrq.index = idx;
    d.cpuIrq.addr  = vectorAddr(base, idx);
    d.resetAddr    = resetVectorFuse ? bootStart(bootSizeFuses) : `APP_TABLE;

    // Wake is independent of the global enable; only its edge part depends on the I/O clock
    d.wakeReq = |(pinChangeEnable & pcEvent) |
                |(extIrqEnable & ((extLow & levelMode) | extEdge));

    // ------------------------------------------------------------------
    // Pull-ups and read-back
    // ------------------------------------------------------------------
    d.pullupEnable = ~pinDirectionBit & pinOutputBit & {(`PC_PINS-1){~q.pullupKill}};
    d.rdata = 8'h00;
    if (regRead && hitsControl(regAddr, regIoSpace)) begin
      d.rdata[`BIT_VEC_UNLOCK]  = q.vcState == VC_OPEN;
      d.rdata[`BIT_VEC_SELECT]  = q.vecSel;
      d.rdata[`BIT_PULLUP_KILL] = q.pullupKill;
      d.rdata[`BIT_BOD_UNLOCK]  = q.bodUnlockCnt != 3'h0;
      d.rdata[`BIT_BOD_OFF]     = q.bodsPending;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q         <= '0;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs, all from the state register
  // ----------------------------------------------------------------------
  assign regRdata        = q.rdata;
  assign cpuIrq          = q.cpuIrq;
  assign resetAddr       = q.resetAddr;
  assign wakeReq         = q.wakeReq;
  assign bodOffThisSleep = q.bodOffThisSleep;
  assign extIrqFlags     = q.extFlags;
  assign pinChangeFlags  = q.pcFlags;
  assign pullupEnable    = q.pullupEnable;

endmodule

// ===== hw/pin_change_detect.sv
// Pin-change detection in three groups, on the system clock.
// Assumes pin inputs are synchronous; bit 15 has no pin and is ignored.
`timescale 1ns/1ns
`include "irq_ctl_params.svh"

module pin_change_detect
  import irq_ctl_pkg::*;
(
  // Clock and reset
  input  wire logic                     clk,
  input  wire logic                     rst,
  // Pins and masks
  input  wire logic [`PC_PINS-1:0]      pins,
  input  wire logic [`PC_PINS-1:0]      mask,
  // One-cycle group events
  output logic      [`PC_GROUPS-1:0]    groupEvent
);

  pc_det_s q;
  pc_det_s d;

  always_comb begin
    logic [`PC_PINS-1:0] toggled;
    toggled = (pins ^ q.prev) & mask;
    d = q;
    d.prev = pins;
    // No I/O clock enable: usable as a wake source
    d.evt[0] = |(toggled & `PC_GROUP0);
    d.evt[1] = |(toggled & `PC_GROUP1);
    d.evt[2] = |(toggled & `PC_GROUP2);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign groupEvent = q.evt;

endmodule

// ===== sim/cpu_core_model.sv
// Core stand-in: pulses instruction ends and takes offered vectors.
// Assumes the block holds its request until acknowledged.
`timescale 1ns/1ns

module cpu_core_model
  import irq_ctl_pkg::*;
(
  // Clock and reset
  input  wire logic     clk,
  input  wire logic     rst,
  // Vector handshake
  input  wire cpu_irq_s cpuIrq,
  input  wire logic     slowAck,
  output logic          cpuIrqAck,
  output logic          instrDone
);
  logic [2:0] waitCnt_q;

  // Slow mode leaves a request pending, as a long instruction would
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      waitCnt_q <= 3'h0;
      cpuIrqAck <= 1'b0;
      instrDone <= 1'b0;
    end else begin
      instrDone <= ~instrDone;
      cpuIrqAck <= cpuIrq.req && !cpuIrqAck && waitCnt_q == (slowAck ? 3'h5 : 3'h1);
      waitCnt_q <= (cpuIrq.req && !cpuIrqAck) ? waitCnt_q + 3'h1 : 3'h0;
    end
  end
endmodule

// ===== sim/irq_vector_select_sva.sv
// Port assertions for the interrupt-side control block.
// Assumes fuses fixed at a 2K boot section and the boot lock never set.
`timescale 1ns/1ns
`include "irq_ctl_params.svh"

module irq_vector_select_sva
  import irq_ctl_pkg::*;
(
  // Clock and reset
  input wire logic                   clk,
  input wire logic                   rst,
  // Register port
  input wire logic                   regWrite,
  input wire logic                   regRead,
  input wire logic                   regIoSpace,
  input wire logic [7:0]             regAddr,
  input wire logic [7:0]             regWdata,
  input wire logic [7:0]             regRdata,
  // Core side and fuses
  input wire logic                   cpuIrqAck,
  input wire cpu_irq_s               cpuIrq,
  input wire logic [`FLASH_AW-1:0]   resetAddr,
  input wire logic                   resetVectorFuse,
  input wire logic [1:0]             bootSizeFuses,
  input wire logic                   appLockBit,
  // Pins
  input wire logic [`EXT_PINS-1:0]   extIrqPins,
  input wire logic [2*`EXT_PINS-1:0] extSenseControl,
  input wire logic [`EXT_PINS-1:0]   extIrqEnable,
  input wire logic [`EXT_PINS-1:0]   extIrqFlags,
  input wire logic [`PC_PINS-2:0]    pullupEnable
);
  logic       hit;
  logic [3:0] bodAge_q;

  assign hit = regIoSpace ? regAddr == `MCU_CONTROL_DATA_ADDR - `IO_SPACE_OFFSET
                          : regAddr == `MCU_CONTROL_DATA_ADDR;

  // Saturates so an old unlock never looks fresh
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bodAge_q <= 4'hf;
    end else if (regWrite && hit && regWdata == 8'h60) begin
      bodAge_q <= 4'h0;
    end else if (bodAge_q != 4'hf) begin
      bodAge_q <= bodAge_q + 4'h1;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_unlock;
    regWrite && hit && regWdata == 8'h01;
  endsequence
  sequence s_read;
    regRead && hit;
  endsequence
  sequence s_kill;
    regWrite && hit && regWdata[`BIT_PULLUP_KILL] ##1 !regWrite;
  endsequence

  a_unlock_blocks_req: assert property (s_unlock |=> !cpuIrq.req [*3])
    else $error("request offered during vector unlock");
  a_unlock_times_out: assert property (
    s_unlock ##1 !regWrite [*6] ##0 s_read |=> !regRdata[`BIT_VEC_UNLOCK])
    else $error("vector unlock still open");
  a_brownout_off_in_sleep_expired: assert property (
    regRead && hit && bodAge_q > 4'h8 |=> !regRdata[`BIT_BOD_OFF])
    else $error("brown-out bit set outside its sequence");
  a_boot_reset_addr: assert property (
    resetVectorFuse && bootSizeFuses == 2'h1 |=> resetAddr == `BOOT_START_01)
    else $error("reset address wrong");
  a_kill_pullups: assert property (s_kill |=> pullupEnable == '0)
    else $error("pull-up on while killed");
  a_vector_addr: assert property (
    cpuIrq.req |-> (cpuIrq.addr - {10'h0, cpuIrq.index, 1'b0}) inside
                   {`APP_TABLE, `BOOT_START_01})
    else $error("vector address off its table");
  a_level_keeps_req: assert property (
    (extSenseControl[1:0] == 2'h0 && extIrqEnable[0] && !extIrqPins[0] && !appLockBit
     && !cpuIrqAck) [*6] |-> cpuIrq.req)
    else $error("low level not requesting");
  a_level_flag_clear: assert property (
    extSenseControl[1:0] == 2'h0 && $past(extSenseControl[1:0]) == 2'h0 |-> !extIrqFlags[0])
    else $error("flag set in level mode");
endmodule

bind irq_vector_select irq_vector_select_sva chk (.*);

// ===== sim/tb.sv
// Self-checking bench for the interrupt-side control block.
// Assumes a 2K boot section and the core model.
`timescale 1ns/1ns

module tb
  import irq_ctl_pkg::*;
;
  logic        clk, rst, regWrite, regRead, regIoSpace, instrDone, execInBoot;
  logic        cpuIrqAck, sleepExec, resetVectorFuse, appLockBit, slowAck;
  logic        wakeReq, bodOffThisSleep;
  logic [7:0]  regAddr, regWdata, regRdata;
  logic [1:0]  bootSizeFuses, extIrqPins, extIrqEnable, extFlagWriteOne, extIrqFlags;
  logic [3:0]  extSenseControl;
  logic [23:0] pinChangeInput, pinChangeMask;
  logic [2:0]  pinChangeEnable, pcFlagWriteOne, pinChangeFlags;
  logic [22:0] pinDirectionBit, pinOutputBit, pullupEnable;
  logic [13:0] resetAddr;
  cpu_irq_s    cpuIrq;
  int          n_errors, num_checks, cycles;
  int          pcPin[4] = '{3, 12, 20, 15};
  logic [2:0]  pcExp[4] = '{3'h1, 3'h2, 3'h4, 3'h0};
  logic [1:0]  eCode[5] = '{2'h1, 2'h2, 2'h2, 2'h3, 2'h3};
  logic        eFrom[5] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
  logic        eExp[5]  = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1};

  irq_vector_select dut (
    .clk, .rst, .regWrite, .regRead, .regIoSpace, .regAddr, .regWdata, .regRdata,
    .globalIrqEnable(1'b1), .instrDone, .execInBoot, .cpuIrqAck, .sleepExec,
    .ioClkEn(1'b1), .cpuIrq, .resetAddr, .wakeReq, .bodOffThisSleep, .resetVectorFuse,
    .bootSizeFuses, .appLockBit, .bootLockBit(1'b0), .extIrqPins, .extSenseControl,
    .extIrqEnable, .extFlagWriteOne, .extIrqFlags, .pinChangeInput, .pinChangeMask,
    .pinChangeEnable, .pcFlagWriteOne, .pinChangeFlags, .pinDirectionBit, .pinOutputBit,
    .pullupEnable
  );
  cpu_core_model core (.clk, .rst, .cpuIrq, .slowAck, .cpuIrqAck, .instrDone);

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Addresses below 0x40 go through the I/O space
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    regWrite <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    regIoSpace <= a < 8'h40;
    @(posedge clk);
    regWrite <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic [7:0] m = 8'hff);
    @(posedge clk);
    regRead <= 1'b1;
    regAddr <= a;
    regIoSpace <= a < 8'h40;
    @(posedge clk);
    regRead <= 1'b0;
    #1 chk(regRdata & m, exp);
  endtask

  task automatic want_irq(input logic [13:0] addr);
    repeat (40) if (cpuIrq.req !== 1'b1) @(negedge clk);
    chk(cpuIrq.addr, addr);
  endtask

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Ceiling far above scenario length
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      n_errors++;
      final_report();
    end
  end

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    {regWrite, regRead, regIoSpace, regAddr, regWdata, execInBoot, sleepExec, appLockBit,
     slowAck, extIrqEnable, extFlagWriteOne, extSenseControl, pinChangeInput, pinChangeMask,
     pinChangeEnable, pcFlagWriteOne, pinDirectionBit} = '0;
    {resetVectorFuse, bootSizeFuses, extIrqPins, pinOutputBit} = '1;
    bootSizeFuses = 2'h1;
    rst = 1'b1;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    rd(8'h55, 8'h00);
    rd(8'h35, 8'h00);
    rd(8'h56, 8'h00);
    chk(resetAddr, 14'h3c00);
    chk(pullupEnable, 23'h7fffff);
    wr(8'h55, 8'h10);
    rd(8'h35, 8'h10);
    chk(pullupEnable, 23'h0);
    wr(8'h55, 8'h02);
    rd(8'h55, 8'h00);
    wr(8'h55, 8'h01);
    wr(8'h35, 8'h02);
    rd(8'h55, 8'h02);
    wr(8'h55, 8'h01);
    repeat (4) @(posedge clk);
    rd(8'h55, 8'h02);
    wr(8'h55, 8'h00);
    rd(8'h55, 8'h02);
    @(posedge clk) pinChangeMask <= 24'hffffff;
    foreach (pcPin[k]) begin
      @(posedge clk) pinChangeInput[pcPin[k]] <= ~pinChangeInput[pcPin[k]];
      repeat (6) @(posedge clk);
      #1 chk(pinChangeFlags, pcExp[k]);
      @(posedge clk) pcFlagWriteOne <= 3'h7;
      @(posedge clk) pcFlagWriteOne <= 3'h0;
    end
    @(posedge clk) pinChangeEnable <= 3'h1;
    @(posedge clk) pinChangeInput[3] <= 1'b0;
    want_irq(14'h3c06);
    foreach (eCode[k]) begin
      @(posedge clk) begin
        extSenseControl <= {2'h0, eCode[k]};
        extIrqPins[0] <= eFrom[k];
      end
      repeat (6) @(posedge clk);
      extFlagWriteOne <= 2'h1;
      @(posedge clk) extFlagWriteOne <= 2'h0;
      extIrqPins[0] <= ~eFrom[k];
      repeat (6) @(posedge clk);
      #1 chk(extIrqFlags[0], eExp[k]);
    end
    @(posedge clk) begin
      appLockBit <= 1'b1;
      pinChangeEnable <= 3'h0;
      extSenseControl <= 4'h0;
      extIrqEnable <= 2'h1;
      extIrqPins[0] <= 1'b0;
    end
    repeat (10) @(negedge clk) chk(cpuIrq.req, 1'b0);
    @(posedge clk) execInBoot <= 1'b1;
    want_irq(14'h3c02);
    @(posedge clk) begin
      appLockBit <= 1'b0;
      slowAck <= 1'b1;
    end
    repeat (12) @(posedge clk);
    want_irq(14'h3c02);
    chk(extIrqFlags, 2'h0);
    @(posedge clk) extIrqPins[0] <= 1'b1;
    wr(8'h55, 8'h40);
    rd(8'h55, 8'h00, 8'h40);
    @(posedge clk) sleepExec <= 1'b1;
    @(posedge clk) sleepExec <= 1'b0;
    #1 chk(bodOffThisSleep, 1'b0);
    wr(8'h55, 8'h60);
    wr(8'h55, 8'h40);
    rd(8'h55, 8'h40, 8'h40);
    @(posedge clk) sleepExec <= 1'b1;
    @(posedge clk) sleepExec <= 1'b0;
    #1 chk(bodOffThisSleep, 1'b1);
    repeat (4) @(posedge clk);
    rd(8'h55, 8'h00, 8'h40);
    final_report();
  end
endmodule
